// ### inc/dhra_consts.vh
// Constants of the dual host register access block
`ifndef DHRA_CONSTS_VH
`define DHRA_CONSTS_VH
`define DHRA_DATA_W      8
`define DHRA_BITS_PER_B  4'h8
`define DHRA_ADDR_RST    8'h00
`define DHRA_DATA_RST    8'h00
`define DHRA_BUF_DEPTH   2
`define DHRA_SYNC_RST    1'b0
`define DHRA_SCLK_RST    1'b0
`define DHRA_PIN_IDLE    12'h2e0
`define DHRA_STRAP_WAIT  2'h2
`define DHRA_BUS_PERIOD_NS 160
`define DHRA_CLK_PERIOD_NS 20
`endif

// ### rtl/dhra_skid_buf.v
// Two-entry buffer with valid and ready on both sides
module dhra_skid_buf #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
      mem_reg[0] <= {WIDTH{1'b0}};
      mem_reg[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'd1;
      else if (pop && !push)
        count_reg <= count_reg - 2'd1;
    end
  end
endmodule

// ### rtl/dhra_host_port.v
// Host access port: parallel multiplexed bus or serial synchronous link
`include "dhra_consts.vh"

// Notes on behaviour
// - Strap high enables serial pins and ignores the parallel strobes.
// - Strap low enables the parallel port on all eight bus lines.
// - The address is latched on the falling edge of the latch strobe.
// - Store strobe rising edge writes, read strobe low reads the latched address.
// - The first serial byte is the address, data bytes follow.
// - Direction pin high reads, low writes, set at access start.
// - With auto decrement set the address drops by one after each data byte.
// - Every serial byte is shifted most significant bit first.
// - Serial input is sampled on the rising serial clock edge.
// - With edge select low, serial output changes on the rising edge.
// - With edge select high, serial output changes on the falling edge.
module dhra_host_port (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       interface_choice_strap,
  input  wire       chip_select_n,
  input  wire [7:0] muxed_bus_in,
  output reg  [7:0] muxed_bus_out,
  output reg        muxed_bus_oe,
  input  wire       bus_latch_strobe,
  input  wire       read_strobe_n,
  input  wire       store_strobe_n,
  input  wire       serial_clk,
  input  wire       serial_in,
  output reg        serial_out,
  input  wire       direction_select_n,
  input  wire       output_edge_select,
  input  wire       auto_decrement_enable,
  output wire [7:0] reg_addr,
  output wire [7:0] reg_wdata,
  output wire       reg_wvalid,
  input  wire       reg_wready,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata
);
  // ****************************************************
  // Reset release and input synchronisers
  // ****************************************************
  reg        rst_s1_reg;
  reg        rst_n_reg;
  reg [11:0] sync1_reg;
  reg [11:0] sync2_reg;
  reg [11:0] prev_reg;
  wire       rst_n;
  wire [11:0] raw_in;

  assign rst_n  = rst_n_reg;
  assign raw_in = {serial_clk, serial_in, direction_select_n,
                   output_edge_select, chip_select_n, read_strobe_n,
                   store_strobe_n, bus_latch_strobe, muxed_bus_in[3:0]};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  reg [3:0] bus_hi_s1_reg;
  reg [3:0] bus_hi_s2_reg;
  reg       strap_s1_reg;
  reg       strap_s2_reg;
  reg       serial_mode_reg;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Idle pin levels, so no false edge follows reset
      sync1_reg     <= `DHRA_PIN_IDLE;
      sync2_reg     <= `DHRA_PIN_IDLE;
      prev_reg      <= `DHRA_PIN_IDLE;
      bus_hi_s1_reg <= 4'h0;
      bus_hi_s2_reg <= 4'h0;
      strap_s1_reg  <= `DHRA_SYNC_RST;
      strap_s2_reg  <= `DHRA_SYNC_RST;
    end else begin
      sync1_reg     <= raw_in;
      sync2_reg     <= sync1_reg;
      prev_reg      <= sync2_reg;
      bus_hi_s1_reg <= muxed_bus_in[7:4];
      bus_hi_s2_reg <= bus_hi_s1_reg;
      strap_s1_reg  <= interface_choice_strap;
      strap_s2_reg  <= strap_s1_reg;
    end
  end

  // Strap is static, so one capture after reset is enough
  // Taken only once the strap has crossed both sync stages
  // strap held fixed
  reg [1:0] strap_wait_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode_reg <= 1'b0;
      strap_wait_reg  <= 2'h0;
    end else if (strap_wait_reg != 2'h3) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      if (strap_wait_reg == `DHRA_STRAP_WAIT)
        serial_mode_reg <= strap_s2_reg;
    end
  end

  wire [7:0] bus_s    = {bus_hi_s2_reg, sync2_reg[3:0]};
  wire       sclk_s   = sync2_reg[11];
  wire       sdi_s    = sync2_reg[10];
  wire       dir_rd_s = sync2_reg[9];
  wire       edge_s   = sync2_reg[8];
  wire       cs_n_s   = sync2_reg[7];
  wire       rd_n_s   = sync2_reg[6];
  wire       wr_n_s   = sync2_reg[5];
  wire       ale_s    = sync2_reg[4];
  wire       sclk_rise = sclk_s && !prev_reg[11];
  wire       sclk_fall = !sclk_s && prev_reg[11];
  wire       cs_open   = !cs_n_s && prev_reg[7];
  wire       ale_fall  = !ale_s && prev_reg[4];
  wire       rd_fall   = !rd_n_s && prev_reg[6];
  wire       wr_rise   = wr_n_s && !prev_reg[5];

  // ****************************************************
  // Write path buffer
  // ****************************************************
  reg  [7:0] wq_addr;
  reg  [7:0] wq_data;
  reg        wq_valid;
  wire       wq_ready;
  wire [15:0] wq_out;

  dhra_skid_buf #(.WIDTH(16)) u_wbuf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   ({wq_addr, wq_data}),
    .in_valid  (wq_valid),
    .in_ready  (wq_ready),
    .out_data  (wq_out),
    .out_valid (reg_wvalid),
    .out_ready (reg_wready)
  );
  assign reg_wdata = wq_out[7:0];

  // ****************************************************
  // Parallel port and serial port
  // ****************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [7:0] latch_addr_reg;
  reg [7:0] rd_addr_reg;
  reg [1:0] state_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] ser_addr_reg;
  reg       dir_rd_reg;
  reg       load_pend_reg;
  reg       rd_pend_reg;

  // Queued write owns the address lines while it waits
  assign reg_addr = reg_wvalid ? wq_out[15:8] : rd_addr_reg;

  function [7:0] next_addr;
    input [7:0] a;
    input       dec;
    begin
      next_addr = dec ? a - 8'h01 : a;
    end
  endfunction

  wire [7:0] shift_next = {shift_reg[6:0], sdi_s};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_addr_reg <= `DHRA_ADDR_RST;
      rd_addr_reg    <= `DHRA_ADDR_RST;
      muxed_bus_out  <= `DHRA_DATA_RST;
      muxed_bus_oe   <= 1'b0;
      state_reg      <= ST_IDLE;
      shift_reg      <= `DHRA_DATA_RST;
      tx_reg         <= `DHRA_DATA_RST;
      bit_cnt_reg    <= 4'h0;
      ser_addr_reg   <= `DHRA_ADDR_RST;
      dir_rd_reg     <= 1'b0;
      serial_out     <= `DHRA_SCLK_RST;
      wq_addr        <= `DHRA_ADDR_RST;
      wq_data        <= `DHRA_DATA_RST;
      wq_valid       <= 1'b0;
      reg_rd         <= 1'b0;
      load_pend_reg  <= 1'b0;
      rd_pend_reg    <= 1'b0;
    end else begin
      reg_rd <= 1'b0;
      // Read data stands the cycle after the request
      rd_pend_reg <= reg_rd;
      if (wq_valid && wq_ready)
        wq_valid <= 1'b0;
      if (!serial_mode_reg) begin
        if (ale_fall)
          latch_addr_reg <= bus_s;
        rd_addr_reg <= latch_addr_reg;
        if (rd_fall && !cs_n_s)
          reg_rd <= 1'b1;
        if (rd_pend_reg)
          muxed_bus_out <= reg_rdata;
        muxed_bus_oe <= !rd_n_s && !cs_n_s;
        if (wr_rise && !cs_n_s && !wq_valid) begin
          wq_addr  <= latch_addr_reg;
          wq_data  <= bus_s;
          wq_valid <= 1'b1;
        end
      end else begin
        muxed_bus_oe <= 1'b0;
        rd_addr_reg  <= ser_addr_reg;
        if (cs_n_s) begin
          state_reg   <= ST_IDLE;
          load_pend_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
        end else begin
          if (cs_open || state_reg == ST_IDLE) begin
            dir_rd_reg  <= dir_rd_s;
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
          end
          if (sclk_rise && state_reg != ST_IDLE) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == `DHRA_BITS_PER_B - 4'h1) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                ser_addr_reg  <= shift_next;
                state_reg     <= ST_DATA;
                load_pend_reg <= dir_rd_reg;
              end else if (state_reg == ST_DATA) begin
                if (!dir_rd_reg && !wq_valid) begin
                  wq_addr  <= ser_addr_reg;
                  wq_data  <= shift_next;
                  wq_valid <= 1'b1;
                end
                ser_addr_reg  <= next_addr(ser_addr_reg,
                                           auto_decrement_enable);
                load_pend_reg <= dir_rd_reg && auto_decrement_enable;
                if (!auto_decrement_enable)
                  state_reg <= ST_DONE;
              end
            end
          end
          if (load_pend_reg) begin
            reg_rd        <= 1'b1;
            load_pend_reg <= 1'b0;
          end
          if (rd_pend_reg)
            tx_reg <= reg_rdata;
          if (state_reg == ST_DATA && dir_rd_reg) begin
            if ((edge_s ? sclk_fall : sclk_rise)) begin
              serial_out <= tx_reg[7];
              tx_reg     <= {tx_reg[6:0], 1'b0};
            end
          end
        end
      end
    end
  end
endmodule

// ### sim/dhra_reg_model.sv
// Register file model standing behind the host port
module dhra_reg_model (
  input  wire       clk_sys,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wvalid,
  output reg        reg_wready,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  reg     [7:0] mem [0:255];
  reg     [1:0] cnt = 2'h0;
  integer       i;
  initial begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = ~i[7:0];
    reg_wready = 1'b0;
    reg_rdata = 8'h00;
  end
  // ******
  // Access
  // ******
  always @(posedge clk_sys) begin
    cnt <= cnt + 2'h1;
    // Stalls one cycle in four
    reg_wready <= (cnt != 2'h3);
    if (reg_wvalid && reg_wready)
      mem[reg_addr] <= reg_wdata;
    // Data valid one cycle only
    if (reg_rd)
      reg_rdata <= mem[reg_addr];
    else
      reg_rdata <= ~reg_rdata;
  end
endmodule

// ### sim/dhra_host_port_asserts.sv
// Checker of pin and request timing at the host port
module dhra_host_port_chk (
  input wire       clk_sys,
  input wire       arst_n,
  input wire       interface_choice_strap,
  input wire       chip_select_n,
  input wire       read_strobe_n,
  input wire       direction_select_n,
  input wire       output_edge_select,
  input wire       serial_clk,
  input wire       serial_out,
  input wire [7:0] muxed_bus_out,
  input wire       muxed_bus_oe,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wvalid,
  input wire       reg_wready,
  input wire       reg_rd,
  input wire [7:0] reg_rdata
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire ser_rd = interface_choice_strap && direction_select_n;
  // ******
  // Checks
  // ******
  oe_serial_off_a: assert property (
    interface_choice_strap |-> !muxed_bus_oe) else $error("oe in serial");
  oe_after_read_a: assert property (
    $rose(muxed_bus_oe) |-> !$past(read_strobe_n, 2)
    && !$past(chip_select_n, 2)) else $error("oe without read");
  rd_pulse_a: assert property (
    reg_rd |=> !reg_rd) else $error("read pulse too long");
  wr_hold_a: assert property (
    reg_wvalid && !reg_wready |=> reg_wvalid
    && $stable({reg_addr, reg_wdata})) else $error("write dropped");
  par_rd_data_a: assert property (
    !interface_choice_strap && reg_rd |-> ##2
    muxed_bus_out == $past(reg_rdata)) else $error("bad read data");
  out_rise_a: assert property (
    ser_rd && !chip_select_n && !$past(chip_select_n, 4)
    && !output_edge_select && $changed(serial_out) |-> $past(serial_clk))
    else $error("output off rising edge");
  out_fall_a: assert property (
    ser_rd && !chip_select_n && !$past(chip_select_n, 4)
    && output_edge_select && $changed(serial_out) |-> !$past(serial_clk))
    else $error("output off falling edge");
  idle_no_rd_a: assert property (
    chip_select_n [*8] |-> !reg_rd) else $error("read while idle");
  ser_rd_dir_a: assert property (
    interface_choice_strap && reg_rd |-> direction_select_n)
    else $error("read in write access");
  cover property (reg_wvalid && !reg_wready);
  cover property (muxed_bus_oe);
  cover property (ser_rd && reg_rd);
endmodule

// ### sim/dhra_host_port_tb.sv
// Self-checking bench of the dual host register access port
module dhra_host_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_sys = 1'b0, arst_n = 1'b0, interface_choice_strap = 1'b0;
  reg chip_select_n = 1'b1, read_strobe_n = 1'b1, store_strobe_n = 1'b1;
  reg bus_latch_strobe = 1'b0, serial_clk = 1'b0, serial_in = 1'b0;
  reg direction_select_n = 1'b1, output_edge_select = 1'b0;
  reg auto_decrement_enable = 1'b0;
  reg [7:0] hbus = 8'h00, lfsr = 8'h1e, sa = 8'h00;
  reg [7:0] model [0:255];
  reg [31:0] rx = 32'h0000_0000;
  reg [15:0] exp_q [$];
  wire [7:0] muxed_bus_in, muxed_bus_out, reg_addr, reg_wdata, reg_rdata;
  wire muxed_bus_oe, serial_out, reg_wvalid, reg_wready, reg_rd;
  integer mismatches = 0, tests_run = 0, i;
  always #10 clk_sys = ~clk_sys;
  assign muxed_bus_in = muxed_bus_oe ? muxed_bus_out : hbus;
  dhra_host_port dut (.clk_sys, .arst_n, .interface_choice_strap,
    .chip_select_n, .muxed_bus_in, .muxed_bus_out, .muxed_bus_oe,
    .bus_latch_strobe, .read_strobe_n, .store_strobe_n, .serial_clk,
    .serial_in, .serial_out, .direction_select_n, .output_edge_select,
    .auto_decrement_enable, .reg_addr, .reg_wdata, .reg_wvalid,
    .reg_wready, .reg_rd, .reg_rdata);
  dhra_reg_model rf (.clk_sys, .reg_addr, .reg_wdata, .reg_wvalid,
    .reg_wready, .reg_rd, .reg_rdata);
  // *****
  // Tasks
  // *****
  function [7:0] nxt(input [7:0] v);
    nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task push(input [7:0] a, input [7:0] d);
    model[a] = d;
    exp_q.push_back({a, d});
  endtask
  always @(posedge clk_sys)
    if (reg_wvalid && reg_wready) begin
      chk8(reg_addr, exp_q[0][15:8]);
      chk8(reg_wdata, exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  task par_acc(input [7:0] a, input [7:0] d, input rd_op);
    chip_select_n <= 1'b0;
    hbus <= a;
    bus_latch_strobe <= 1'b1;
    cyc(4);
    bus_latch_strobe <= 1'b0;
    cyc(4);
    hbus <= d;
    read_strobe_n <= !rd_op;
    store_strobe_n <= rd_op;
    if (!rd_op)
      push(a, d);
    cyc(8);
    if (rd_op)
      chk8(muxed_bus_out, model[a]);
    if (rd_op)
      chk8({7'h00, muxed_bus_oe}, 8'h01);
    read_strobe_n <= 1'b1;
    store_strobe_n <= 1'b1;
    cyc(4);
    chip_select_n <= 1'b1;
    hbus <= ~d;
    cyc(8);
  endtask
  task sbyte(input [7:0] v);
    integer k;
    for (k = 7; k >= 0; k = k - 1) begin
      serial_in <= v[k];
      cyc(4);
      serial_clk <= 1'b1;
      cyc(1);
      rx = {rx[30:0], serial_out};
      cyc(3);
      serial_clk <= 1'b0;
    end
  endtask
  task ser_acc(input [7:0] a, input rd_op, input integer n);
    reg [7:0] d1, d0;
    d1 = nxt(lfsr);
    d0 = nxt(d1);
    lfsr = d0;
    chip_select_n <= 1'b0;
    direction_select_n <= rd_op;
    auto_decrement_enable <= (n == 2);
    if (!rd_op)
      push(a, d1);
    if (!rd_op && n == 2)
      push(a - 8'h01, d0);
    cyc(4);
    sbyte(a);
    sbyte(d1);
    if (n == 2)
      sbyte(d0);
    cyc(5);
    // Rising-edge output lags the host sample by one edge
    if (!output_edge_select)
      rx = {rx[30:0], serial_out};
    chip_select_n <= 1'b1;
    if (rd_op && n == 2)
      chk8(rx[15:8], model[a]);
    if (rd_op)
      chk8(rx[7:0], model[8'(a - n + 1)]);
    cyc(8);
  endtask
  initial begin
    for (i = 0; i < 256; i = i + 1)
      model[i] = ~i[7:0];
    cyc(6);
    arst_n <= 1'b1;
    cyc(6);
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = nxt(lfsr);
      par_acc(lfsr, nxt(lfsr), 1'b0);
      par_acc(lfsr, 8'h00, 1'b1);
    end
    arst_n <= 1'b0;
    interface_choice_strap <= 1'b1;
    hbus <= 8'h00;
    cyc(6);
    arst_n <= 1'b1;
    cyc(6);
    for (i = 0; i < 8; i = i + 1) begin
      if (!i[0])
        sa = nxt(lfsr);
      output_edge_select <= i[1];
      ser_acc(sa, i[0], 2 - i[2]);
    end
    cyc(20);
    chk8(8'(exp_q.size()), 8'h00);
    conclude;
  end
  initial begin
    #200000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule
bind dhra_host_port dhra_host_port_chk chk (.clk_sys, .arst_n,
  .interface_choice_strap, .chip_select_n, .read_strobe_n,
  .direction_select_n, .output_edge_select, .serial_clk, .serial_out,
  .muxed_bus_out, .muxed_bus_oe, .reg_addr, .reg_wdata, .reg_wvalid,
  .reg_wready, .reg_rd, .reg_rdata);
